/* File: inc/pltlk_map.svh */
// Purpose: constants for the palette lookup host port
// Assumes: one core clock at 40 MHz
// Notes:   register select codes are {reg_select_hi, reg_select_lo}
`ifndef PLTLK_MAP_SVH
`define PLTLK_MAP_SVH
`define PLTLK_SEL_PTR_WR   2'b00
`define PLTLK_SEL_PTR_RD   2'b11
`define PLTLK_SEL_COLOUR   2'b01
`define PLTLK_SEL_MASK     2'b10
`define PLTLK_MASK_RST     8'hff
`define PLTLK_PTR_RST      8'h00
`define PLTLK_CHAN_W       6
`define PLTLK_ENTRY_W      18
`define PLTLK_DEPTH        256
`define PLTLK_CLK_MHZ      40
`define PLTLK_PIX_DIV      2
`endif

/* File: inc/pltlk_pkg.sv */
// Purpose: types for the palette lookup host port
// Assumes: nothing
// Notes:   byte phase of a colour sequence
package pltlk_pkg;
  typedef enum logic [2:0] {
    PLTLK_RED   = 3'b001,
    PLTLK_GREEN = 3'b010,
    PLTLK_BLUE  = 3'b100
  } pltlk_phase_t;
endpackage

/* File: design/pltlk_top.sv */
// Purpose: palette lookup front end with asynchronous host port
// Assumes: host strobes and pixel inputs sampled on i_core_clk;
//          pixel rate is a one-cycle enable from a divider
// Notes:   host edges are detected after a four-stage synchroniser
// Operation
// - select code 00 pointer write, 11 pointer read, 01 colour, 10 mask.
// - register select captured when a host strobe falls; host holds it.
// - written byte stored into selected register at write strobe rise.
// - selected register driven onto host data while read strobe is low.
// - read strobe rise ends a read and releases data; write strobe plays no part.
// - each pixel edge latches index and blank; mask forms lookup address.
// - palette holds 256 entries of 18 bits, feeding three 6-bit channels.
// - index and blank pass a three-stage pixel-clocked pipeline.
// - blank low forces all-zero channel codes, ignoring palette colour.
// - host palette updates keep working during blanking.
// - host accesses accepted any time and synchronised internally.
// - colour moves as red, green, blue bytes; low six bits, top zero.
// - third written byte stores staged colour at pointer, then increments.
// - read-mode pointer write copies entry to staging and increments.
// - mask bit one passes index bit, zero clears; host ignores mask.
`timescale 1ns/1ps
`include "pltlk_map.svh"
module pltlk_top (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_pixel_index_in,
  input  wire logic       i_blank_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_reg_select_lo,
  input  wire logic       i_reg_select_hi,
  input  wire logic [7:0] i_host_data_bus,
  output logic      [7:0] o_host_data_bus,
  output logic            o_host_data_oe,
  output logic      [5:0] o_red,
  output logic      [5:0] o_green,
  output logic      [5:0] o_blue,
  output logic            o_pix_en
);
  // synchronisers: stage one is read only by stage two
  logic [1:0] rd_s1_r;
  logic [1:0] rd_s2_r;
  logic [1:0] wr_s1_r;
  logic [1:0] wr_s2_r;
  logic       rd_d_r, wr_d_r;
  logic [1:0] sel_now_r, sel_r;
  logic [7:0] data_now_r, data_r;
  logic       rd_fall, rd_rise, wr_fall, wr_rise;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_s1_r    <= 2'b11;
      rd_s2_r    <= 2'b11;
      wr_s1_r    <= 2'b11;
      wr_s2_r    <= 2'b11;
      rd_d_r     <= 1'b1;
      wr_d_r     <= 1'b1;
      sel_now_r  <= 2'b00;
      data_now_r <= 8'h00;
    end else begin
      rd_s1_r    <= {rd_s1_r[0], i_rd_n};
      rd_s2_r    <= {rd_s2_r[0], rd_s1_r[1]};
      wr_s1_r    <= {wr_s1_r[0], i_wr_n};
      wr_s2_r    <= {wr_s2_r[0], wr_s1_r[1]};
      rd_d_r     <= rd_s2_r[1];
      wr_d_r     <= wr_s2_r[1];
      sel_now_r  <= {i_reg_select_hi, i_reg_select_lo};
      data_now_r <= i_host_data_bus;
    end
  end
  // strobes run three cycles behind the select/data registers; host setup and hold
  // windows cover that, so no extra delay line is spent on data
  assign rd_fall = rd_d_r & ~rd_s2_r[1];
  assign rd_rise = ~rd_d_r & rd_s2_r[1];
  assign wr_fall = wr_d_r & ~wr_s2_r[1];
  assign wr_rise = ~wr_d_r & wr_s2_r[1];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_r  <= `PLTLK_SEL_PTR_WR;
      data_r <= 8'h00;
    end else begin
      if (rd_fall || wr_fall) begin
        sel_r <= sel_now_r;
      end
      if (!wr_s2_r[1]) begin
        data_r <= data_now_r;
      end
    end
  end

  // pixel enable divider
  logic [1:0] div_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 2'd0;
    end else if (div_r == 2'(`PLTLK_PIX_DIV - 1)) begin
      div_r <= 2'd0;
    end else begin
      div_r <= div_r + 2'd1;
    end
  end
  assign o_pix_en = (div_r == 2'd0);

  // palette storage and host registers
  logic [`PLTLK_ENTRY_W-1:0] pal_r [`PLTLK_DEPTH];
  logic [7:0]                ptr_r, mask_r;
  logic [`PLTLK_ENTRY_W-1:0] stage_r;
  pltlk_pkg::pltlk_phase_t   phase_r;
  logic                      do_write, do_read;

  function automatic pltlk_pkg::pltlk_phase_t next_phase(
    input pltlk_pkg::pltlk_phase_t p);
    case (p)
      pltlk_pkg::PLTLK_RED:   next_phase = pltlk_pkg::PLTLK_GREEN;
      pltlk_pkg::PLTLK_GREEN: next_phase = pltlk_pkg::PLTLK_BLUE;
      default:                next_phase = pltlk_pkg::PLTLK_RED;
    endcase
  endfunction

  assign do_write = wr_rise && (sel_r == `PLTLK_SEL_COLOUR);
  assign do_read  = rd_rise && (sel_r == `PLTLK_SEL_COLOUR);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_r   <= `PLTLK_PTR_RST;
      mask_r  <= `PLTLK_MASK_RST;
      stage_r <= '0;
      phase_r <= pltlk_pkg::PLTLK_RED;
    end else if (wr_rise && sel_r == `PLTLK_SEL_PTR_WR) begin
      ptr_r   <= data_r;
      phase_r <= pltlk_pkg::PLTLK_RED;
    end else if (wr_rise && sel_r == `PLTLK_SEL_PTR_RD) begin
      stage_r <= pal_r[data_r];
      ptr_r   <= data_r + 8'd1;
      phase_r <= pltlk_pkg::PLTLK_RED;
    end else if (wr_rise && sel_r == `PLTLK_SEL_MASK) begin
      mask_r <= data_r;
    end else if (do_write) begin
      // stored at blue; no blanking check so updates run always
      phase_r <= next_phase(phase_r);
      case (phase_r)
        pltlk_pkg::PLTLK_RED:   stage_r[17:12] <= data_r[5:0];
        pltlk_pkg::PLTLK_GREEN: stage_r[11:6]  <= data_r[5:0];
        default: begin
          stage_r[5:0] <= data_r[5:0];
          ptr_r        <= ptr_r + 8'd1;
        end
      endcase
    end else if (do_read) begin
      phase_r <= next_phase(phase_r);
      if (phase_r == pltlk_pkg::PLTLK_BLUE) begin
        stage_r <= pal_r[ptr_r];
        ptr_r   <= ptr_r + 8'd1;
      end
    end
  end

  // palette write; mask is not involved on the host path
  always_ff @(posedge i_core_clk) begin
    if (do_write && phase_r == pltlk_pkg::PLTLK_BLUE) begin
      pal_r[ptr_r] <= {stage_r[17:6], data_r[5:0]};
    end
  end

  // host read data
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_data_bus <= 8'h00;
    end else begin
      case (sel_r)
        `PLTLK_SEL_PTR_WR,
        `PLTLK_SEL_PTR_RD: o_host_data_bus <= ptr_r;
        `PLTLK_SEL_MASK:   o_host_data_bus <= mask_r;
        default: begin
          case (phase_r)
            pltlk_pkg::PLTLK_RED:
              o_host_data_bus <= {2'b00, stage_r[17:12]};
            pltlk_pkg::PLTLK_GREEN:
              o_host_data_bus <= {2'b00, stage_r[11:6]};
            default:
              o_host_data_bus <= {2'b00, stage_r[5:0]};
          endcase
        end
      endcase
    end
  end
  // drive while read is low, release when read is high, whatever write does
  assign o_host_data_oe = ~rd_s2_r[1];

  // video path: latch, lookup, output latch
  logic [7:0] pix_r;
  logic [1:0] blank_n_r;
  logic [17:0] look_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pix_r     <= 8'h00;
      blank_n_r <= 2'b00;
      look_r    <= '0;
      o_red     <= 6'h00;
      o_green   <= 6'h00;
      o_blue    <= 6'h00;
    end else if (o_pix_en) begin
      // relies on valid inputs at every pixel edge
      pix_r     <= i_pixel_index_in & mask_r;
      blank_n_r <= {blank_n_r[0], i_blank_n};
      look_r    <= pal_r[pix_r];
      if (blank_n_r[1]) begin
        {o_red, o_green, o_blue} <= look_r;
      end else begin
        {o_red, o_green, o_blue} <= '0;
      end
    end
  end
  // host spacing of 3 or 6 pixel periods covers edge latency
endmodule

/* File: verif/pltlk_monitor.sv */
// Purpose: port checks for pltlk_top
// Assumes: host and pixel latencies as handed over
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`include "pltlk_map.svh"
module pltlk_monitor (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_blank_n,
  input wire logic       i_rd_n,
  input wire logic       i_reg_select_lo,
  input wire logic       i_reg_select_hi,
  input wire logic [7:0] o_host_data_bus,
  input wire logic       o_host_data_oe,
  input wire logic [5:0] o_red,
  input wire logic [5:0] o_green,
  input wire logic [5:0] o_blue,
  input wire logic       o_pix_en
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // enable trails the read pin by four edges of the synchroniser
  sequence s_rd_low; !i_rd_n [*5]; endsequence
  // select capture and the data register add two edges after that
  sequence s_col_rd;
    ({i_reg_select_hi, i_reg_select_lo} == `PLTLK_SEL_COLOUR
     && !i_rd_n) [*7];
  endsequence
  property p_oe_on; s_rd_low |-> o_host_data_oe; endproperty
  property p_oe_off; i_rd_n [*5] |-> !o_host_data_oe; endproperty
  property p_rise; $rose(o_host_data_oe) |-> !$past(i_rd_n, 4); endproperty
  property p_fall; $fell(o_host_data_oe) |-> $past(i_rd_n, 4); endproperty
  property p_top; s_col_rd |-> o_host_data_bus[7:6] == 2'b00; endproperty
  property p_pix; o_pix_en |=> !o_pix_en ##1 o_pix_en; endproperty
  // outputs move only behind a pixel enable, never mid-period
  property p_hold;
    !$past(o_pix_en) |-> $stable({o_red, o_green, o_blue});
  endproperty
  property p_blank;
    !i_blank_n [*8] |-> ##2 ({o_red, o_green, o_blue} == 18'h0_0000);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe off");
  a_oe_off: assert property (p_oe_off) else $error("oe on");
  a_rise: assert property (p_rise) else $error("oe rise");
  a_fall: assert property (p_fall) else $error("oe fall");
  a_top: assert property (p_top) else $error("top bits");
  a_pix: assert property (p_pix) else $error("pix rate");
  a_hold: assert property (p_hold) else $error("rgb moved");
  a_blank: assert property (p_blank) else $error("blank");
endmodule
bind pltlk_top pltlk_monitor u_mon (
  .i_core_clk      (i_core_clk),
  .i_rst           (i_rst),
  .i_blank_n       (i_blank_n),
  .i_rd_n          (i_rd_n),
  .i_reg_select_lo (i_reg_select_lo),
  .i_reg_select_hi (i_reg_select_hi),
  .o_host_data_bus (o_host_data_bus),
  .o_host_data_oe  (o_host_data_oe),
  .o_red           (o_red),
  .o_green         (o_green),
  .o_blue          (o_blue),
  .o_pix_en        (o_pix_en)
);

/* File: verif/pltlk_host.sv */
// Purpose: host bus model
// Assumes: acts on falling edges
// Notes:   one access per call
`timescale 1ns/1ps
module pltlk_host (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_host_data_bus,
  input  wire logic       i_host_data_oe,
  output logic            o_rd_n = 1'b1,
  output logic            o_wr_n = 1'b1,
  output logic            o_reg_select_lo = 1'b0,
  output logic            o_reg_select_hi = 1'b0,
  output logic      [7:0] o_host_data_bus = 8'h00
);
  task automatic acc(input logic w, input logic [1:0] s,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge i_core_clk);
    {o_reg_select_hi, o_reg_select_lo} = s;
    o_host_data_bus = w ? d : ~o_host_data_bus;
    @(negedge i_core_clk);
    o_wr_n = !w;
    o_rd_n = w;
    repeat (8) @(negedge i_core_clk);
    q = i_host_data_oe ? i_host_data_bus : ~o_host_data_bus;
    {o_rd_n, o_wr_n} = 2'b11;
    repeat (4) @(negedge i_core_clk);
    // released data must not look held
    o_host_data_bus = ~o_host_data_bus;
    repeat (12) @(negedge i_core_clk);
  endtask
endmodule

/* File: verif/tb_pltlk_top.sv */
// Purpose: self-checking bench for pltlk_top
// Assumes: host model owns the bus pins
// Notes:   pixel inputs change on falling edges
`timescale 1ns/1ps
`include "pltlk_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("wrong value %0t %h %h", $time, a, b); end end
module tb_pltlk_top;
  logic       i_core_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [7:0] i_pixel_index_in = 8'h00;
  logic       i_blank_n = 1'b1;
  logic       i_rd_n, i_wr_n, i_reg_select_lo, i_reg_select_hi;
  logic [7:0] i_host_data_bus, o_host_data_bus, q;
  logic       o_host_data_oe, o_pix_en;
  logic [5:0] o_red, o_green, o_blue;
  int         error_cnt = 0;
  int         check_count = 0;
  logic [7:0] exp6 [6] = '{8'h01, 8'h3e, 8'h15, 8'h2a, 8'h00, 8'h3f};
  always #12.5 i_core_clk = ~i_core_clk;
  pltlk_top u_dut (.*);
  pltlk_host u_host (.i_core_clk, .i_host_data_bus(o_host_data_bus),
    .i_host_data_oe(o_host_data_oe), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n),
    .o_reg_select_lo(i_reg_select_lo), .o_reg_select_hi(i_reg_select_hi),
    .o_host_data_bus(i_host_data_bus));
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    u_host.acc(1'b1, s, d, q);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    u_host.acc(1'b0, s, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset();
    rd(`PLTLK_SEL_MASK, `PLTLK_MASK_RST);
    rd(`PLTLK_SEL_PTR_WR, `PLTLK_PTR_RST);
  endtask
  task automatic t_palette();
    wr(`PLTLK_SEL_PTR_WR, 8'h05);
    foreach (exp6[i]) wr(`PLTLK_SEL_COLOUR, exp6[i] | 8'hc0);
    wr(`PLTLK_SEL_PTR_RD, 8'h05);
    foreach (exp6[i]) rd(`PLTLK_SEL_COLOUR, exp6[i]);
    rd(`PLTLK_SEL_PTR_RD, 8'h08);
  endtask
  task automatic t_blank();
    i_blank_n = 1'b0;
    wr(`PLTLK_SEL_MASK, 8'h0f);
    wr(`PLTLK_SEL_PTR_WR, 8'h10);
    wr(`PLTLK_SEL_COLOUR, 8'h11);
    wr(`PLTLK_SEL_PTR_WR, 8'h10);
    wr(`PLTLK_SEL_COLOUR, 8'h0a);
    wr(`PLTLK_SEL_COLOUR, 8'h0b);
    wr(`PLTLK_SEL_COLOUR, 8'h0c);
    `CHK({o_red, o_green, o_blue}, 18'h0_0000)
    wr(`PLTLK_SEL_PTR_RD, 8'h10);
    rd(`PLTLK_SEL_COLOUR, 8'h0a);
    rd(`PLTLK_SEL_COLOUR, 8'h0b);
    rd(`PLTLK_SEL_COLOUR, 8'h0c);
  endtask
  task automatic t_video();
    i_blank_n = 1'b1;
    i_pixel_index_in = 8'hf5;
    repeat (16) @(negedge i_core_clk);
    `CHK({o_red, o_green, o_blue}, {6'h01,6'h3e,6'h15})
    i_pixel_index_in = 8'h16;
    repeat (16) @(negedge i_core_clk);
    `CHK({o_red, o_green, o_blue}, {6'h2a,6'h00,6'h3f})
  endtask
  initial begin
    #200_000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge i_core_clk);
    i_rst = 1'b0;
    t_reset();
    t_palette();
    t_blank();
    t_video();
    test_done();
  end
endmodule
